// file: logic/target_mode_supervisor_consts.svh
// constants for the target mode supervisor
`ifndef TARGET_MODE_SUPERVISOR_CONSTS_SVH
`define TARGET_MODE_SUPERVISOR_CONSTS_SVH

`define TMS_CLK_HZ 8000000
`define TMS_CTRL_BAUD 9600
`define TMS_DATA_BAUD 38400
`define TMS_DATA_BIT_CYC (`TMS_CLK_HZ / `TMS_DATA_BAUD)
`define TMS_BIT_CYC (`TMS_CLK_HZ / `TMS_CTRL_BAUD)
`define TMS_HALF_CYC (`TMS_BIT_CYC / 2)
`define TMS_CNT_W 10
`define TMS_RST_HOLD_US 100
`define TMS_RST_HOLD_CYC ((`TMS_RST_HOLD_US * (`TMS_CLK_HZ / 1000000)))
`define TMS_SETUP_CYC 16
`define TMS_HOLD_W 10
`define TMS_SYNC_BYTE 8'hA5
`define TMS_CMD_EXT 8'h31
`define TMS_CMD_INT 8'h32
`define TMS_CMD_BOOT 8'h33
`define TMS_ACK_BYTE 8'h06

`endif

// file: logic/target_mode_supervisor_pkg.sv
// types for the target mode supervisor
package target_mode_supervisor_pkg;

	typedef enum logic [2:0]
	{
		MODE_EXT_FLASH = 3'b001,
		MODE_INT_FLASH = 3'b010,
		MODE_SINGLE_BOOT = 3'b100
	} mode_t;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_ASSERT = 4'b0010,
		ST_SETUP = 4'b0100,
		ST_RUN = 4'b1000
	} seq_t;

	typedef struct packed
	{
		logic ext_access_sel_n;
		logic boot_sel_n;
		logic reset_n;
	} target_ctl_t;

endpackage

// file: logic/target_mode_supervisor.sv
// serial command supervisor driving target boot mode and reset
`timescale 1ns/100ps
`default_nettype none
`include "target_mode_supervisor_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module target_mode_supervisor
(
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// shared serial lines
	input wire logic i_rxd,
	output logic o_txd,
	output logic o_txd_oe,
	// target control
	output target_mode_supervisor_pkg::target_ctl_t o_target,
	// status
	output logic o_led_red
);

	//////////////////////////////////////////////////////////////////////
	// receive path: sync, 9600 baud uart

	logic rx_meta_r;
	logic rx_sync_r;
	logic rx_busy_r;
	logic [`TMS_CNT_W-1:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_shift_r;
	logic rx_valid_r;
	logic [7:0] rx_byte_r;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end
		else
		begin
			rx_meta_r <= i_rxd;
			rx_sync_r <= rx_meta_r;
		end
	end

	// one bit period counted from 8 MHz; 38400 traffic mostly fails framing
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 10'h000;
			rx_bit_r <= 4'h0;
			rx_shift_r <= 8'h00;
			rx_valid_r <= 1'b0;
			rx_byte_r <= 8'h00;
		end
		else
		begin
			rx_valid_r <= 1'b0;
			if (!rx_busy_r)
			begin
				if (!rx_sync_r)
				begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= 10'(`TMS_HALF_CYC);
					rx_bit_r <= 4'h0;
				end
			end
			else if (rx_cnt_r != 10'h000)
				rx_cnt_r <= rx_cnt_r - 10'h001;
			else
			begin
				rx_cnt_r <= 10'(`TMS_BIT_CYC - 1);
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0 && rx_sync_r)
					rx_busy_r <= 1'b0; // false start glitch
				else if (rx_bit_r == 4'h9)
				begin
					rx_busy_r <= 1'b0;
					// no parity, one stop bit; bad stop drops the byte
					if (rx_sync_r)
					begin
						rx_valid_r <= 1'b1;
						rx_byte_r <= rx_shift_r;
					end
				end
				else if (rx_bit_r != 4'h0)
					rx_shift_r <= {rx_sync_r, rx_shift_r[7:1]};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sequence matcher: sync byte then command byte

	logic armed_r;
	logic cmd_hit_r;
	target_mode_supervisor_pkg::mode_t cmd_mode_r;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			armed_r <= 1'b0;
			cmd_hit_r <= 1'b0;
			cmd_mode_r <= target_mode_supervisor_pkg::MODE_EXT_FLASH;
		end
		else
		begin
			cmd_hit_r <= 1'b0;
			if (rx_valid_r)
			begin
				armed_r <= (rx_byte_r == `TMS_SYNC_BYTE);
				if (armed_r)
				begin
					case (rx_byte_r)
						`TMS_CMD_EXT:
						begin
							cmd_hit_r <= 1'b1;
							cmd_mode_r <= target_mode_supervisor_pkg::MODE_EXT_FLASH;
						end
						`TMS_CMD_INT:
						begin
							cmd_hit_r <= 1'b1;
							cmd_mode_r <= target_mode_supervisor_pkg::MODE_INT_FLASH;
						end
						`TMS_CMD_BOOT:
						begin
							cmd_hit_r <= 1'b1;
							cmd_mode_r <= target_mode_supervisor_pkg::MODE_SINGLE_BOOT;
						end
						default:
							cmd_hit_r <= 1'b0;
					endcase
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// reset sequencer: assert, settle mode lines, release

	target_mode_supervisor_pkg::seq_t seq_r;
	target_mode_supervisor_pkg::mode_t mode_r;
	logic [`TMS_HOLD_W-1:0] wait_r;
	logic boot_pend_r;
	logic tx_go;

	// start from a reset pulse so external flash is chosen at power-up
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			seq_r <= target_mode_supervisor_pkg::ST_ASSERT;
			mode_r <= target_mode_supervisor_pkg::MODE_EXT_FLASH;
			wait_r <= 10'(`TMS_RST_HOLD_CYC);
		end
		else
		begin
			case (seq_r)
				target_mode_supervisor_pkg::ST_IDLE:
					seq_r <= target_mode_supervisor_pkg::ST_RUN;
				target_mode_supervisor_pkg::ST_RUN:
					if (cmd_hit_r)
					begin
						seq_r <= target_mode_supervisor_pkg::ST_ASSERT;
						wait_r <= 10'(`TMS_RST_HOLD_CYC);
					end
				target_mode_supervisor_pkg::ST_ASSERT:
					if (wait_r != 10'h000)
						wait_r <= wait_r - 10'h001;
					else
					begin
						// mode lines change only while reset held
						mode_r <= cmd_mode_r;
						seq_r <= target_mode_supervisor_pkg::ST_SETUP;
						wait_r <= 10'(`TMS_SETUP_CYC);
					end
				target_mode_supervisor_pkg::ST_SETUP:
					if (wait_r != 10'h000)
						wait_r <= wait_r - 10'h001;
					else
						seq_r <= target_mode_supervisor_pkg::ST_RUN;
				default:
					seq_r <= target_mode_supervisor_pkg::ST_ASSERT;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			boot_pend_r <= 1'b0;
		else if (cmd_hit_r)
			boot_pend_r <= 1'b1;
		else if (tx_go)
			boot_pend_r <= 1'b0;
	end

	// target control lines from flops
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_target.ext_access_sel_n <= 1'b0;
			o_target.boot_sel_n <= 1'b1;
			o_target.reset_n <= 1'b0;
		end
		else
		begin
			// high for internal flash and single boot, low only for external flash
			o_target.ext_access_sel_n <=
				(mode_r != target_mode_supervisor_pkg::MODE_EXT_FLASH);
			o_target.boot_sel_n <=
				(mode_r != target_mode_supervisor_pkg::MODE_SINGLE_BOOT);
			o_target.reset_n <=
				(seq_r == target_mode_supervisor_pkg::ST_RUN);
		end
	end

	// red led lit while target held in reset or not in external mode
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			o_led_red <= 1'b1;
		else
			o_led_red <= (seq_r != target_mode_supervisor_pkg::ST_RUN)
				|| (mode_r != target_mode_supervisor_pkg::MODE_EXT_FLASH);
	end

	//////////////////////////////////////////////////////////////////////
	// acknowledge transmitter, tristated when silent

	logic tx_busy_r;
	logic [`TMS_CNT_W-1:0] tx_cnt_r;
	logic [3:0] tx_bit_r;
	logic [9:0] tx_frame_r;

	// ack after target released so it never collides with target replies
	assign tx_go = boot_pend_r && !tx_busy_r && !rx_busy_r
		&& seq_r == target_mode_supervisor_pkg::ST_RUN && !cmd_hit_r;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tx_busy_r <= 1'b0;
			tx_cnt_r <= 10'h000;
			tx_bit_r <= 4'h0;
			tx_frame_r <= 10'h3FF;
		end
		else if (tx_go)
		begin
			tx_busy_r <= 1'b1;
			tx_cnt_r <= 10'(`TMS_BIT_CYC - 1);
			tx_bit_r <= 4'h0;
			tx_frame_r <= {1'b1, `TMS_ACK_BYTE, 1'b0};
		end
		else if (tx_busy_r)
		begin
			if (tx_cnt_r != 10'h000)
				tx_cnt_r <= tx_cnt_r - 10'h001;
			else
			begin
				tx_cnt_r <= 10'(`TMS_BIT_CYC - 1);
				tx_frame_r <= {1'b1, tx_frame_r[9:1]};
				tx_bit_r <= tx_bit_r + 4'h1;
				if (tx_bit_r == 4'h9)
					tx_busy_r <= 1'b0;
			end
		end
	end

	assign o_txd = tx_frame_r[0];
	assign o_txd_oe = tx_busy_r;

	//////////////////////////////////////////////////////////////////////
	// checks

	property p_txd_release;
		@(posedge i_sys_clk) disable iff (i_rst)
		$fell(o_txd_oe) |-> $past(o_txd) && $past(tx_bit_r) == 4'h9;
	endproperty
	a_txd_release: assert property (p_txd_release)
		else $error("txd released before stop bit ended");

	property p_mode_stable;
		@(posedge i_sys_clk) disable iff (i_rst)
		$rose(o_target.reset_n) |->
			$stable(o_target.ext_access_sel_n) && $stable(o_target.boot_sel_n)
			&& !$past(o_target.reset_n, 2);
	endproperty
	a_mode_stable: assert property (p_mode_stable)
		else $error("mode lines moved at reset release");

	sequence s_hit;
		cmd_hit_r;
	endsequence
	sequence s_reset_low;
		##1 seq_r == target_mode_supervisor_pkg::ST_ASSERT ##1 !o_target.reset_n;
	endsequence
	property p_cmd_resets;
		@(posedge i_sys_clk) disable iff (i_rst)
		s_hit and seq_r == target_mode_supervisor_pkg::ST_RUN |-> s_reset_low;
	endproperty
	a_cmd_resets: assert property (p_cmd_resets)
		else $error("command did not reset target");

	property p_ea_level;
		@(posedge i_sys_clk) disable iff (i_rst)
		o_target.reset_n |->
			o_target.ext_access_sel_n
				== (mode_r != target_mode_supervisor_pkg::MODE_EXT_FLASH);
	endproperty
	a_ea_level: assert property (p_ea_level)
		else $error("ext access level wrong");

	property p_led;
		@(posedge i_sys_clk) disable iff (i_rst)
		!o_target.reset_n ##1 !o_target.reset_n |-> o_led_red;
	endproperty
	a_led: assert property (p_led)
		else $error("led off during target reset");

	property p_stop_bit;
		@(posedge i_sys_clk) disable iff (i_rst)
		rx_valid_r |-> $past(rx_sync_r);
	endproperty
	a_stop_bit: assert property (p_stop_bit)
		else $error("byte accepted without stop bit");

	property p_ignore;
		@(posedge i_sys_clk) disable iff (i_rst)
		!rx_valid_r |=> !cmd_hit_r;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("command without byte");

	property p_bit_time;
		@(posedge i_sys_clk) disable iff (i_rst)
		tx_busy_r && tx_cnt_r == 10'h000 && tx_bit_r != 4'h9 |=>
			tx_cnt_r == 10'(`TMS_BIT_CYC - 1);
	endproperty
	a_bit_time: assert property (p_bit_time)
		else $error("bit period wrong");

endmodule
`default_nettype wire

// file: tb/host_target_model.sv
// host tool and target model on the shared serial lines
`timescale 1ns/100ps
`default_nettype none
`include "target_mode_supervisor_consts.svh"
module host_target_model
(
	// clock
	input wire logic i_sys_clk,
	// shared lines and target control
	input wire logic i_txd_line,
	input wire target_mode_supervisor_pkg::target_ctl_t i_target,
	output logic o_rxd
);
	logic [7:0] rx_q[$];
	logic [7:0] rx_b;
	target_mode_supervisor_pkg::target_ctl_t mode_at_rise;
	int rises = 0;
	initial
		o_rxd = 1'b1;
	//////////////////////////////////////////////////////////////////////////
	// host side: 8N1, lsb first, data lines only, either line rate
	task automatic send_byte(input logic [7:0] b, input int bit_cyc);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge i_sys_clk);
			#1 o_rxd = f[i];
			repeat (bit_cyc - 1) @(posedge i_sys_clk);
		end
	endtask
	// released line floats to its pull-up, so a start bit is ours to see
	initial
	begin
		forever
		begin
			@(negedge i_txd_line);
			repeat (`TMS_HALF_CYC) @(posedge i_sys_clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (`TMS_BIT_CYC) @(posedge i_sys_clk);
				rx_b[i] = i_txd_line;
			end
			repeat (`TMS_BIT_CYC) @(posedge i_sys_clk);
			if (i_txd_line === 1'b1)
				rx_q.push_back(rx_b);
		end
	end
	//////////////////////////////////////////////////////////////////////////
	// target latches its mode on the reset release edge
	always @(posedge i_target.reset_n)
	begin
		mode_at_rise = i_target;
		rises++;
	end
endmodule
`default_nettype wire

// file: tb/test_target_mode_supervisor.sv
// self-checking bench for the target mode supervisor
`timescale 1ns/100ps
`default_nettype none
`include "target_mode_supervisor_consts.svh"
module test_target_mode_supervisor;
	logic sys_clk;
	logic rst;
	logic rxd;
	logic txd;
	logic txd_oe;
	logic led;
	wire logic txd_line;
	target_mode_supervisor_pkg::target_ctl_t tgt;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	// pull-up on the shared line; target stays silent here
	assign txd_line = txd_oe ? txd : 1'b1;
	target_mode_supervisor u_target_mode_supervisor
	(
		.i_sys_clk(sys_clk),
		.i_rst(rst),
		.i_rxd(rxd),
		.o_txd(txd),
		.o_txd_oe(txd_oe),
		.o_target(tgt),
		.o_led_red(led)
	);
	host_target_model u_host_target_model
	(
		.i_sys_clk(sys_clk),
		.i_txd_line(txd_line),
		.i_target(tgt),
		.o_rxd(rxd)
	);
	//////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			err_count++;
		end
	endtask
	task automatic wait_rst_n(input logic lvl, input int max);
		for (int i = 0; i < max && tgt.reset_n !== lvl; i++)
			@(posedge sys_clk);
		#1 chk("reset_n level", {7'h00, lvl}, {7'h00, tgt.reset_n});
	endtask
	//////////////////////////////////////////////////////////////////////////
	task automatic check_reset_default();
		chk("ctl in reset", 8'h02, {5'h00, tgt});
		chk("oe in reset", 8'h00, {7'h00, txd_oe});
		chk("led in reset", 8'h01, {7'h00, led});
		@(posedge sys_clk);
		#1 rst = 1'b0;
		wait_rst_n(1'b1, 2000);
		chk("boot mode", 8'h03, {5'h00, u_host_target_model.mode_at_rise});
		chk("led ext run", 8'h00, {7'h00, led});
	endtask
	task automatic check_stray_cmd();
		// a sync byte inside target-rate traffic must not arm the matcher
		u_host_target_model.send_byte(`TMS_SYNC_BYTE, `TMS_DATA_BIT_CYC);
		// let the slow receiver finish the garbage frame first
		repeat (6000) @(posedge sys_clk);
		u_host_target_model.send_byte(`TMS_CMD_INT, `TMS_BIT_CYC);
		repeat (900) @(posedge sys_clk);
		#1 chk("rises", 8'h01, u_host_target_model.rises[7:0]);
		chk("no ack", 8'h00, 8'(u_host_target_model.rx_q.size()));
	endtask
	task automatic run_cmd(input logic [7:0] cmd, input logic [2:0] mode);
		u_host_target_model.send_byte(`TMS_SYNC_BYTE, `TMS_BIT_CYC);
		u_host_target_model.send_byte(cmd, `TMS_BIT_CYC);
		wait_rst_n(1'b0, 1000);
		chk("led busy", 8'h01, {7'h00, led});
		wait_rst_n(1'b1, 2000);
		chk("mode", {5'h00, mode}, {5'h00, u_host_target_model.mode_at_rise});
		chk("led mode", {7'h00, mode != 3'h3}, {7'h00, led});
		repeat (4) @(posedge sys_clk);
		#1 chk("mode held", {5'h00, mode}, {5'h00, tgt});
		for (int i = 0; i < 12000 && u_host_target_model.rx_q.size() == 0; i++)
			@(posedge sys_clk);
		#1 chk("ack", `TMS_ACK_BYTE, u_host_target_model.rx_q.pop_front());
		repeat (600) @(posedge sys_clk);
		#1 chk("oe idle", 8'h00, {7'h00, txd_oe});
	endtask
	// own reset in mid-run must bring the target back to external flash
	task automatic check_mid_reset();
		@(posedge sys_clk);
		#1 rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 check_reset_default();
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// full run is about 96k cycles of 833-cycle bits
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 99000)
		begin
			err_count++;
			test_done();
		end
	end
	initial
	begin
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 check_reset_default();
		check_stray_cmd();
		run_cmd(`TMS_CMD_INT, 3'h7);
		check_mid_reset();
		run_cmd(`TMS_CMD_BOOT, 3'h5);
		run_cmd(`TMS_CMD_EXT, 3'h3);
		test_done();
	end
endmodule
`default_nettype wire
